// ---- rtl/isa_regs.vh ----
// Constants for the two-wire slave acknowledge and handshake block
`ifndef ISA_REGS_VH
`define ISA_REGS_VH
`define ISA_ADDR_HI 3'h5
`define ISA_ADDR_W 7
`define ISA_BITS_PER_BYTE 4'h8
`define ISA_FIFO_DEPTH 8
`define ISA_ST_IDLE 3'h0
`define ISA_ST_ADDR 3'h1
`define ISA_ST_ACK 3'h2
`define ISA_ST_RX 3'h3
`define ISA_ST_TX 3'h4
`define ISA_ST_TXACK 3'h5
`define ISA_ST_IGNORE 3'h6
`endif

// ---- rtl/isa_fifo.v ----
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module isa_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clocking
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign push = clk_en & in_valid & in_ready;
	assign pop = clk_en & out_valid & out_ready;
	assign out_data = mem[rd_q];
	always @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // isa_fifo

// ---- rtl/isa_slave.v ----
// Two-wire serial slave port: acknowledge, refusal and read handshake
// What this block does
// RULE1: Master acknowledges each read byte it wants continued by holding data low.
// RULE2: Master clocks every acknowledge bit, whoever drives it.
// RULE3: Device refuses bytes when mode invalid, hash busy or write cycle running.
// RULE4: Master ends a read by leaving data high on the last acknowledge.
// RULE5: After master not-acknowledge, device releases data; master then sends STOP.
// RULE6: Device never drives the serial clock; it is input only.
// RULE7: Data line is open-drain: pull low or release.
// RULE8: Accepted bytes are acknowledged by pulling data low through clock high.
// RULE9: Transmit bits change after the falling clock edge, valid at rising edge.
// RULE10: Bytes travel most significant bit first, then one acknowledge bit.
// RULE11: After a refusal, bus activity is ignored until next START or STOP.
`timescale 1ns/1ps
`include "isa_regs.vh"
module isa_slave #(
	parameter DEPTH = `ISA_FIFO_DEPTH,
	parameter AW = 3
) (
	// Clocking
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	// Bus pins; clock is input only
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe,
	// Address select
	input wire [3:0] dev_addr,
	// Refusal causes
	input wire mode_invalid,
	input wire hash_busy,
	input wire nv_write_busy,
	// Received bytes to the core
	output wire rx_valid,
	input wire rx_ready,
	output wire [7:0] rx_data,
	// Bytes to transmit from the core
	input wire tx_valid,
	output wire tx_ready,
	input wire [7:0] tx_data,
	// Status
	output reg busy_q,
	output reg start_q,
	output reg stop_q,
	output reg master_nack_q
);
	reg scl_m_q, scl_s_q, scl_d_q;
	reg sda_m_q, sda_s_q, sda_d_q;
	reg [2:0] st_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg rw_q;
	reg drive_low_q;
	reg fifo_push_q;
	reg [7:0] fifo_data_q;
	reg tx_pop;
	wire scl_rise;
	wire scl_fall;
	wire start_ev;
	wire stop_ev;
	wire refuse;
	wire fifo_in_ready;
	wire [6:0] my_addr;

	// Released line reads high through the pull-up; only low is driven
	assign sda_o = 1'b0; // RULE7
	assign sda_oe = drive_low_q; // RULE7
	// No clock output exists, so the clock is never stretched
	assign scl_rise = scl_s_q & ~scl_d_q; // RULE6
	assign scl_fall = ~scl_s_q & scl_d_q;
	assign start_ev = scl_s_q & scl_d_q & ~sda_s_q & sda_d_q;
	assign stop_ev = scl_s_q & scl_d_q & sda_s_q & ~sda_d_q;
	// Full receive buffer also refuses, so no byte is ever dropped
	assign refuse = mode_invalid | hash_busy | nv_write_busy |
		~fifo_in_ready; // RULE3
	assign my_addr = {`ISA_ADDR_HI, dev_addr};
	assign tx_ready = tx_pop;

	always @* begin
		tx_pop = 1'b0;
		if (clk_en && st_q == `ISA_ST_TXACK && scl_rise && !sda_s_q)
			tx_pop = tx_valid;
	end

	isa_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_rx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.in_valid(fifo_push_q),
		.in_ready(fifo_in_ready),
		.in_data(fifo_data_q),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_d_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_d_q <= 1'b1;
			st_q <= `ISA_ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			drive_low_q <= 1'b0;
			fifo_push_q <= 1'b0;
			fifo_data_q <= 8'h00;
			busy_q <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			master_nack_q <= 1'b0;
		end else if (clk_en) begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_d_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_d_q <= sda_s_q;
			fifo_push_q <= 1'b0;
			start_q <= start_ev;
			stop_q <= stop_ev;
			master_nack_q <= 1'b0;
			if (start_ev) begin
				// Any START, repeated or not, restarts address reception
				st_q <= `ISA_ST_ADDR; // RULE11
				bit_q <= 4'h0;
				drive_low_q <= 1'b0;
				busy_q <= 1'b1;
			end else if (stop_ev) begin
				st_q <= `ISA_ST_IDLE; // RULE11
				drive_low_q <= 1'b0;
				busy_q <= 1'b0;
			end else begin
				case (st_q)
				`ISA_ST_ADDR, `ISA_ST_RX: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s_q}; // RULE10
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall &&
						bit_q == `ISA_BITS_PER_BYTE) begin
						bit_q <= 4'h0;
						if (st_q == `ISA_ST_ADDR &&
							sh_q[7:1] != my_addr) begin
							st_q <= `ISA_ST_IGNORE;
						end else if (refuse) begin
							// Line left released during acknowledge
							st_q <= `ISA_ST_IGNORE; // RULE3
						end else begin
							drive_low_q <= 1'b1; // RULE8
							st_q <= `ISA_ST_ACK;
							if (st_q == `ISA_ST_ADDR)
								rw_q <= sh_q[0];
							else begin
								fifo_push_q <= 1'b1;
								fifo_data_q <= sh_q;
							end
						end
					end
				end
				`ISA_ST_ACK: begin
					// Held low through the whole acknowledge high phase
					if (scl_fall) begin // RULE8
						bit_q <= 4'h0;
						if (rw_q) begin
							if (tx_valid) begin
								sh_q <= {tx_data[6:0], 1'b0};
								drive_low_q <= ~tx_data[7]; // RULE9
								st_q <= `ISA_ST_TX;
							end else begin
								drive_low_q <= 1'b0;
								st_q <= `ISA_ST_IGNORE; // RULE3
							end
						end else begin
							drive_low_q <= 1'b0;
							st_q <= `ISA_ST_RX;
						end
					end
				end
				`ISA_ST_TX: begin
					if (scl_rise)
						bit_q <= bit_q + 4'h1;
					else if (scl_fall) begin
						if (bit_q == `ISA_BITS_PER_BYTE) begin
							// Release for the master's acknowledge bit
							drive_low_q <= 1'b0; // RULE2
							st_q <= `ISA_ST_TXACK;
						end else begin
							drive_low_q <= ~sh_q[7]; // RULE9
							sh_q <= {sh_q[6:0], 1'b0}; // RULE10
						end
					end
				end
				`ISA_ST_TXACK: begin
					if (scl_rise) begin
						if (sda_s_q) begin
							// Master ended the read; stay off the line
							master_nack_q <= 1'b1; // RULE4
							st_q <= `ISA_ST_IGNORE; // RULE5
						end else if (!tx_valid) begin
							st_q <= `ISA_ST_IGNORE; // RULE1
						end else begin
							sh_q <= tx_data;
							bit_q <= 4'h0;
							st_q <= `ISA_ST_ACK; // RULE1
						end
					end
				end
				`ISA_ST_IGNORE: begin
					drive_low_q <= 1'b0; // RULE11
				end
				`ISA_ST_IDLE: begin
					drive_low_q <= 1'b0;
				end
				default: begin
					st_q <= `ISA_ST_IDLE;
					drive_low_q <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule // isa_slave

// ---- test/isa_slave_asserts.sv ----
// Checker for the two-wire slave port
`timescale 1ns/1ps
module isa_chk (
	// Clocking
	input wire clk,
	input wire reset_n,
	// Bus and causes
	input wire scl_i,
	input wire sda_o,
	input wire sda_oe,
	input wire mode_invalid,
	input wire hash_busy,
	input wire nv_write_busy,
	// Status
	input wire tx_ready,
	input wire busy_q,
	input wire start_q,
	input wire stop_q,
	input wire master_nack_q
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
a_drain_only: assert property (!sda_o) else $error("sda_o high");
a_oe_scl_low: assert property (
	$changed(sda_oe) |-> !scl_i && !$past(scl_i))
	else $error("oe moved in scl high");
a_refuse_cause: assert property (
	$rose(sda_oe) |-> !(mode_invalid | hash_busy | nv_write_busy))
	else $error("ack busy");
a_nack_free: assert property (
	master_nack_q |-> !sda_oe ##1 !sda_oe)
	else $error("oe after nack");
a_start_free: assert property (
	start_q |=> !sda_oe)
	else $error("oe start");
a_stop_idle: assert property (
	stop_q |=> !busy_q && !sda_oe)
	else $error("busy after stop");
a_txr_pulse: assert property (
	tx_ready |-> busy_q ##1 !tx_ready)
	else $error("tx_ready long");
a_idle_quiet: assert property (
	!busy_q |-> !sda_oe)
	else $error("oe idle");
endmodule // isa_chk
bind isa_slave isa_chk chk (.clk(clk), .reset_n(reset_n), .scl_i(scl_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .mode_invalid(mode_invalid),
	.hash_busy(hash_busy), .nv_write_busy(nv_write_busy),
	.tx_ready(tx_ready), .busy_q(busy_q), .start_q(start_q),
	.stop_q(stop_q), .master_nack_q(master_nack_q));

// ---- test/isa_master.sv ----
// Bus master model driving the serial clock and data
`timescale 1ns/1ps
module isa_master (
	// Clocking
	input wire clk,
	// Bus
	input wire sda,
	output reg scl = 1'h1,
	output reg sda_low = 1'h0
);
// Serial clock of 32 ns: 16 ns high, 16 ns low split around the data change
task w(input integer n);
	repeat (n) @(negedge clk);
endtask
task start;
	sda_low = 1'h1;
	w(4);
	scl = 1'h0;
	w(2);
endtask
task stop;
	sda_low = 1'h1;
	w(2);
	scl = 1'h1;
	w(4);
	sda_low = 1'h0;
	w(4);
endtask
task bitx(input b, output r);
	sda_low = !b;
	w(2);
	scl = 1'h1;
	w(4);
	r = sda;
	scl = 1'h0;
	w(2);
endtask
task xfer(input [7:0] d, input a, output [7:0] q, output ak);
	integer i;
	for (i = 7; i >= 0; i--) bitx(d[i], q[i]);
	bitx(a, ak);
	sda_low = 1'h0;
endtask
endmodule // isa_master

// ---- test/isa_slave_test.sv ----
// Testbench for the two-wire slave port
`timescale 1ns/1ps
module isa_slave_test;
reg clk = 1'h0;
reg reset_n = 1'h0;
reg [2:0] cause = 3'h0;
reg rx_ready = 1'h0;
reg tx_valid = 1'h0;
reg [7:0] tx_data = 8'h3C;
reg [7:0] q;
reg ak;
wire scl, sda_low, sda_o, sda_oe, rx_valid;
wire tx_ready, busy_q, start_q, stop_q, master_nack_q;
wire [7:0] rx_data;
// Pull-up gives the high level; the slave only ever pulls low
wire sda = !sda_low & (sda_oe ? sda_o : 1'h1);
integer bad_count = 0;
integer num_checks = 0;
integer i;
integer n_txr = 0;
integer n_nack = 0;
integer n_start = 0;
integer n_stop = 0;
initial forever #2 clk = !clk;
isa_slave uut (.clk(clk), .reset_n(reset_n), .clk_en(1'h1), .scl_i(scl),
	.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr(4'h9),
	.mode_invalid(cause[2]), .hash_busy(cause[1]), .nv_write_busy(cause[0]),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
	.busy_q(busy_q), .start_q(start_q), .stop_q(stop_q),
	.master_nack_q(master_nack_q));
isa_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
// Status pulses last one clock, so each is seen at exactly one falling edge
always @(negedge clk) begin
	if (tx_ready === 1'h1) n_txr++;
	if (master_nack_q === 1'h1) n_nack++;
	if (start_q === 1'h1) n_start++;
	if (stop_q === 1'h1) n_stop++;
end
task chk(input [7:0] g, input [7:0] e);
	num_checks++;
	if (g !== e) begin
		bad_count++;
		$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task end_sim;
	$display("checks=%0d mismatches=%0d", num_checks, bad_count);
	if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
task adr(input rw, input e);
	m.start;
	m.xfer({3'h5, 4'h9, rw}, 1'h1, q, ak);
	chk({7'h0, ak}, {7'h0, e});
endtask
task t_fill;
	integer k;
	adr(1'h0, 1'h0);
	for (i = 0; i < 9; i++) begin
		m.xfer(8'hA0 + i[7:0], 1'h1, q, ak);
		chk({7'h0, ak}, {7'h0, i == 8});
	end
	m.stop;
	for (i = 0; i < 8; i++) begin
		k = 0;
		while (rx_valid !== 1'h1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		if (k == 50) begin
			bad_count++;
			end_sim;
		end
		chk(rx_data, 8'hA0 + i[7:0]);
		rx_ready = 1'h1;
		@(negedge clk);
		rx_ready = 1'h0;
		repeat (2) @(negedge clk);
	end
	$display("fill and drain done");
endtask
task t_refuse;
	for (i = 0; i < 3; i++) begin
		cause = 3'h1 << i;
		adr(1'h0, 1'h1);
		cause = 3'h0;
		m.xfer(8'h55, 1'h1, q, ak);
		chk({7'h0, ak}, 8'h01);
		m.stop;
	end
	// A foreign address is left unanswered and the rest of the frame ignored
	m.start;
	m.xfer({3'h5, 4'h6, 1'h0}, 1'h1, q, ak);
	chk({7'h0, ak}, 8'h01);
	m.xfer(8'h00, 1'h1, q, ak);
	chk({7'h0, ak}, 8'h01);
	m.stop;
	$display("refusal done");
endtask
task t_read;
	tx_valid = 1'h1;
	adr(1'h1, 1'h0);
	chk({7'h0, busy_q}, 8'h01);
	m.xfer(8'hFF, 1'h0, q, ak);
	chk(q, 8'h3C);
	m.xfer(8'hFF, 1'h1, q, ak);
	chk(q, 8'h3C);
	chk({7'h0, ak}, 8'h01);
	m.stop;
	tx_valid = 1'h0;
	chk({7'h0, busy_q}, 8'h00);
	chk(n_txr[7:0], 8'h01);
	chk(n_nack[7:0], 8'h01);
	chk(n_start[7:0], 8'h06);
	chk(n_stop[7:0], 8'h06);
	$display("read done");
endtask
initial begin
	repeat (20) @(negedge clk);
	reset_n = 1'h1;
	repeat (4) @(negedge clk);
	t_fill;
	t_refuse;
	t_read;
	end_sim;
end
endmodule // isa_slave_test
